// ### design/clock_select_and_soft_reset.sv
`timescale 1ns/10ps
// Operation
// RL1: source field selects internal, internal+output, external
// RL2: output pin driven only for code 01
// RL3: clock control resets to 0x20
// RL4: oversampling clock divided by 1/2/4/8
// RL5: output pin clock divided by 1/2/4/8
// RL6: bit1 halves slow clock; bit0 reserved
// RL7: writing 0 to bit7 resets whole device
// RL8: writing 0 to bit6 resets measurement path
// RL9: writing 1 does nothing; reserved bits read zero
module clock_select_and_soft_reset
   import clk_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic fast_internal_oscillator,
   input wire logic ext_clk_tick,
   input wire logic slow_clock,
   output logic osr_tick,
   output logic clk_out,
   output logic clk_out_en,
   output logic slow_tick,
   output logic chip_reset,
   output logic meas_reset
);
   // ---------------------------------------------
   // registers and decode
   // ---------------------------------------------
   logic [7:0] clk_ctl_r;
   logic [7:0] clk_ctl_nxt;
   logic chip_rst_r;
   logic meas_rst_r;
   logic [3:0] chip_cnt_r;
   logic [3:0] meas_cnt_r;
   logic [7:0] rdata_r;
   logic clk_out_r;
   logic slow_prev_r;
   logic slow_half_r;
   logic sel_clk;
   logic sel_rst;
   logic [1:0] src;
   logic src_tick;
   logic out_on;
   logic slow_rise;
   logic chip_start;
   logic meas_start;
   logic [7:0] rd_mux;

   assign sel_clk = (addr == clock_control_addr);
   assign sel_rst = (addr == soft_reset_control_addr);
   assign src = clk_ctl_r[src_hi:src_lo];
   // code 11 is undefined; it falls back to the internal source
   assign src_tick = (src == src_ext) ? ext_clk_tick : fast_internal_oscillator; // RL1
   assign out_on = (src == src_int_out); // RL2
   // only a written 0 starts a reset; a 1 is a no-op
   assign chip_start = wr && sel_rst && !wdata[chip_rst_bit]; // RL7 RL9
   assign meas_start = wr && sel_rst && !wdata[meas_rst_bit]; // RL8 RL9

   // ---------------------------------------------
   // clock control register
   // ---------------------------------------------
   // whole-device soft reset also restores this register; it wins over a write in the
   // same cycle so that no setting written during the reset survives it
   assign clk_ctl_nxt = chip_rst_r ? clock_control_reset :
                        (wr && sel_clk) ? (wdata & clock_control_mask) : clk_ctl_r; // RL6 RL9
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_ctl_r <= clock_control_reset; // RL3
      end else begin
         clk_ctl_r <= clk_ctl_nxt;
      end
   end

   // ---------------------------------------------
   // soft reset sequencers
   // ---------------------------------------------
   // reset bits read 0 while their reset runs, 1 after it ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chip_rst_r <= 1'b0;
         chip_cnt_r <= '0;
      end else if (chip_start) begin
         chip_rst_r <= 1'b1; // RL7
         chip_cnt_r <= 4'(soft_reset_cycles - 1);
      end else if (chip_rst_r) begin
         if (chip_cnt_r == 4'h0) begin
            chip_rst_r <= 1'b0; // RL7
         end else begin
            chip_cnt_r <= chip_cnt_r - 4'h1;
         end
      end
   end

   // the device reset implies a measurement path reset as well
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meas_rst_r <= 1'b0;
         meas_cnt_r <= '0;
      end else if (meas_start || chip_start) begin
         meas_rst_r <= 1'b1; // RL8
         meas_cnt_r <= 4'(soft_reset_cycles - 1);
      end else if (meas_rst_r) begin
         if (meas_cnt_r == 4'h0) begin
            meas_rst_r <= 1'b0; // RL8
         end else begin
            meas_cnt_r <= meas_cnt_r - 4'h1;
         end
      end
   end

   assign chip_reset = chip_rst_r;
   assign meas_reset = meas_rst_r;

   // ---------------------------------------------
   // dividers
   // ---------------------------------------------
   div_if osr_d ();
   div_if out_d ();
   assign osr_d.code = clk_ctl_r[osr_div_hi:osr_div_lo]; // RL4
   assign out_d.code = clk_ctl_r[out_div_hi:out_div_lo]; // RL5

   clk_divider u_osr_div (
      .clk(clk),
      .nrst(nrst),
      .en(src_tick),
      .d(osr_d.div)
   );
   assign osr_tick = osr_d.tick; // RL4

   clk_divider u_out_div (
      .clk(clk),
      .nrst(nrst),
      .en(fast_internal_oscillator),
      .d(out_d.div)
   );

   // output pin toggles per divided tick, held low when disabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_out_r <= 1'b0;
      end else if (!out_on) begin
         clk_out_r <= 1'b0; // RL2
      end else if (out_d.tick) begin
         clk_out_r <= !clk_out_r; // RL5
      end
   end
   assign clk_out = clk_out_r;
   assign clk_out_en = out_on; // RL2

   // ---------------------------------------------
   // slow clock halving
   // ---------------------------------------------
   // history starts high so a pin already high at reset release gives no false edge;
   // the cost is that such a first edge is not counted
   assign slow_rise = slow_clock && !slow_prev_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slow_prev_r <= 1'b1;
         slow_half_r <= 1'b0;
      end else begin
         slow_prev_r <= slow_clock;
         if (slow_rise) begin
            slow_half_r <= !slow_half_r;
         end
      end
   end
   // undivided: every rising edge; halved: every other one
   assign slow_tick = slow_rise && (!clk_ctl_r[slow_half_bit] || slow_half_r); // RL6

   // ---------------------------------------------
   // read path
   // ---------------------------------------------
   assign rd_mux = sel_clk ? clk_ctl_r :
                   sel_rst ? {!chip_rst_r, !meas_rst_r, 6'h00} : 8'h00; // RL9
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_r;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   pin_drive_a: assert property (@(posedge clk) disable iff (!nrst)
      clk_out_en == (clk_ctl_r[src_hi:src_lo] == 2'h1)) else $error("clock pin enable wrong"); // RL2
   pin_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      !clk_out_en |=> !clk_out) else $error("clock pin active while off"); // RL2
   reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      clk_ctl_r[0] == 1'b0) else $error("reserved bit set"); // RL6
   chip_start_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && addr == 8'h09 && !wdata[7]) |=> chip_reset && meas_reset) else $error("device reset missed"); // RL7
   // a rewrite of 0 during the pulse restarts it, so the end is checked from the last start
   chip_end_a: assert property (@(posedge clk) disable iff (!nrst)
      (chip_start ##1 !chip_start [*8]) |=> !chip_reset) else $error("device reset too long"); // RL7
   chip_len_a: assert property (@(posedge clk) disable iff (!nrst)
      chip_start |=> chip_reset [*8]) else $error("device reset cut short"); // RL7
   meas_start_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && addr == 8'h09 && !wdata[6]) |=> meas_reset) else $error("path reset missed"); // RL8
   one_noop_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && addr == 8'h09 && wdata[7] && !chip_reset) |=> !chip_reset) else $error("write 1 reset"); // RL9
   clk_restore_a: assert property (@(posedge clk) disable iff (!nrst)
      chip_reset |=> clk_ctl_r == 8'h20) else $error("clock control not restored"); // RL3
   osr_div_a: assert property (@(posedge clk) disable iff (!nrst)
      (osr_tick && clk_ctl_r[5:4] == 2'h1 && $stable(clk_ctl_r)) |=> !osr_tick) else $error("osr ratio"); // RL4
   slow_pass_a: assert property (@(posedge clk) disable iff (!nrst)
      (slow_rise && !clk_ctl_r[1]) |-> slow_tick) else $error("slow clock not passed"); // RL6
   // no slow tick can appear between rising edges of the slow pin
   slow_idle_a: assert property (@(posedge clk) disable iff (!nrst)
      !slow_rise |-> !slow_tick) else $error("slow tick without edge"); // RL6

   // ---------------------------------------------
   // checks: soft reset
   // ---------------------------------------------
   // the path reset follows either start and keeps its full length
   meas_len_a: assert property (@(posedge clk) disable iff (!nrst)
      (meas_start || chip_start) |=> meas_reset [*8]) else $error("path reset cut short"); // RL8
   meas_end_a: assert property (@(posedge clk) disable iff (!nrst)
      ((meas_start || chip_start) ##1 !(meas_start || chip_start) [*8]) |=> !meas_reset)
      else $error("path reset too long"); // RL8
   // the device reset always covers the measurement path as well
   chip_meas_a: assert property (@(posedge clk) disable iff (!nrst)
      chip_reset |-> meas_reset) else $error("path left out of device reset"); // RL7

   // ---------------------------------------------
   // checks: clocks
   // ---------------------------------------------
   // the oversampling tick may only come with a tick of the selected source
   osr_ext_a: assert property (@(posedge clk) disable iff (!nrst)
      (clk_ctl_r[7:6] == 2'h2 && !ext_clk_tick) |-> !osr_tick) else $error("osr tick off external"); // RL1
   osr_int_a: assert property (@(posedge clk) disable iff (!nrst)
      (clk_ctl_r[7:6] != 2'h2 && !fast_internal_oscillator) |-> !osr_tick)
      else $error("osr tick off internal"); // RL1
   // undivided ratio passes every internal tick straight through
   osr_undiv_a: assert property (@(posedge clk) disable iff (!nrst)
      (clk_ctl_r[5:4] == 2'h0 && clk_ctl_r[7:6] != 2'h2) |-> (osr_tick == fast_internal_oscillator))
      else $error("osr undivided"); // RL4
   // while enabled, the pin only moves on an internal oscillator tick
   out_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (clk_out_en && !fast_internal_oscillator) |=> $stable(clk_out)) else $error("clock pin moved"); // RL5
   out_undiv_a: assert property (@(posedge clk) disable iff (!nrst)
      (clk_out_en && clk_ctl_r[3:2] == 2'h0 && fast_internal_oscillator) |=> (clk_out != $past(clk_out)))
      else $error("clock pin not undivided"); // RL5

   // ---------------------------------------------
   // checks: register port
   // ---------------------------------------------
   // read data stand only in the cycle after a read strobe
   rd_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
      !rd |=> (rdata == 8'h00)) else $error("read data without strobe");
   rd_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && !sel_clk && !sel_rst) |=> (rdata == 8'h00)) else $error("unmapped read not zero"); // RL9
   rd_reserved_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && sel_rst) |=> (rdata[5:0] == 6'h00)) else $error("reserved reset bits set"); // RL9
   rd_done_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && sel_rst && !chip_reset && !meas_reset) |=> (rdata[7:6] == 2'h3))
      else $error("reset bits not back to 1"); // RL7 RL8
   rd_busy_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && sel_rst && meas_reset) |=> !rdata[6]) else $error("path reset bit high while busy"); // RL8
   rd_clock_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd && sel_clk) |=> (rdata == $past(clk_ctl_r))) else $error("clock control read"); // RL3
   // a write lands whole except the reserved bit; apart from it only the device reset moves the register
   wr_clock_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr && sel_clk && !chip_reset) |=> (clk_ctl_r == ($past(wdata) & clock_control_mask)))
      else $error("clock control write"); // RL9
   clk_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (!(wr && sel_clk) && !chip_reset) |=> $stable(clk_ctl_r)) else $error("clock control moved"); // RL9
endmodule : clock_select_and_soft_reset

// ### design/clk_ctl_pkg.sv
package clk_ctl_pkg;
   // ---------------------------------------------
   // register map and layouts
   // ---------------------------------------------
   localparam logic [7:0] clock_control_addr = 8'h08;
   localparam logic [7:0] soft_reset_control_addr = 8'h09;
   localparam logic [7:0] clock_control_reset = 8'h20;
   localparam logic [7:0] soft_reset_control_reset = 8'hc0;
   localparam logic [7:0] clock_control_mask = 8'hfe;
   localparam int src_hi = 7;
   localparam int src_lo = 6;
   localparam int osr_div_hi = 5;
   localparam int osr_div_lo = 4;
   localparam int out_div_hi = 3;
   localparam int out_div_lo = 2;
   localparam int slow_half_bit = 1;
   localparam int chip_rst_bit = 7;
   localparam int meas_rst_bit = 6;
   localparam logic [1:0] src_int_no_out = 2'h0;
   localparam logic [1:0] src_int_out = 2'h1;
   localparam logic [1:0] src_ext = 2'h2;
   // ---------------------------------------------
   // timing: soft reset pulse length
   // ---------------------------------------------
   localparam int clk_period_ns = 10;
   localparam int soft_reset_ns = 80;
   localparam int soft_reset_cycles = (soft_reset_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int div_width = 3;
endpackage : clk_ctl_pkg

// ### design/div_if.sv
`timescale 1ns/10ps
// divider setting and the tick it produces
interface div_if;
   logic [1:0] code;
   logic tick;
   modport ctl (output code, input tick);
   modport div (input code, output tick);
endinterface : div_if

// ### design/clk_divider.sv
`timescale 1ns/10ps
// divide-by 1/2/4/8 enable generator; tick is a one-cycle enable at the divided rate
module clk_divider
   import clk_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic en,
   div_if.div d
);
   logic [div_width-1:0] cnt_r;
   logic [div_width-1:0] lim;
   logic wrap;
   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   assign lim = div_width'((4'h1 << d.code) - 4'h1);
   assign wrap = en && (cnt_r >= lim);
   assign d.tick = wrap;
   // counts source ticks only and holds between them, so a sparse source keeps its ratio;
   // the >= compare restarts the count when a smaller ratio is chosen mid-count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (wrap) begin
         cnt_r <= '0;
      end else if (en) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
endmodule : clk_divider

// ### testbench/test_clock_select_and_soft_reset.sv
`timescale 1ns/10ps
module test_clock_select_and_soft_reset;
   import clk_ctl_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, fast = 0, ext = 0, slow = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
   logic osr_tick, clk_out, clk_out_en, slow_tick, chip_reset, meas_reset;
   int failures = 0, n_tests = 0, cycles = 0, clk_m = 32'h20, clk_model = 32'h20, n, v;

   clock_select_and_soft_reset u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .fast_internal_oscillator(fast), .ext_clk_tick(ext), .slow_clock(slow),
      .osr_tick(osr_tick), .clk_out(clk_out), .clk_out_en(clk_out_en), .slow_tick(slow_tick),
      .chip_reset(chip_reset), .meas_reset(meas_reset));

   // -------------------------------------------
   // clock, source ticks and hang guard
   // -------------------------------------------
   always #5 clk = ~clk;
   // external tick at half rate so a wrong source choice shows up in the counts
   always @(posedge clk) begin
      cycles <= cycles + 1;
      fast <= nrst;
      ext <= ~ext;
      slow <= cycles[1];
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   // -------------------------------------------
   // bus tasks and comparison
   // -------------------------------------------
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // model: clock control keeps bits 7:1; a device soft reset restores its reset value
      if (a == clock_control_addr) begin
         clk_model = d & 8'hfe;
      end
      if (a == soft_reset_control_addr && !d[chip_rst_bit]) begin
         clk_model = 32'h20;
      end
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // counts pulses of one output (cycles high for the two resets) over 64 cycles, a multiple of every period used
   task count(input int which, output int c);
      logic prev;
      begin
         c = 0;
         prev = clk_out;
         repeat (64) begin
            @(negedge clk);
            c += (which == 0 && osr_tick === 1'b1) || (which == 1 && clk_out === 1'b1 && prev === 1'b0) ||
               (which == 2 && slow_tick === 1'b1) || (which == 3 && meas_reset === 1'b1) ||
               (which == 4 && chip_reset === 1'b1);
            prev = clk_out;
         end
      end
   endtask : count

   task complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      v = $urandom(77);
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(clock_control_addr, got);
      check(got, 8'h20);
      rd_reg(soft_reset_control_addr, got);
      check(got, 8'hc0);
      rd_reg(8'h0a, got);
      check(got, 8'h00);
      // every source and every divider code, low two bits random
      for (int s = 0; s < 3; s++) begin
         for (int c = 0; c < 4; c++) begin
            clk_m = (s << 6) | (c << 4) | (c << 2) | ($urandom & 3);
            wr_reg(clock_control_addr, clk_m[7:0]);
            rd_reg(clock_control_addr, got);
            check(got, 8'(clk_model));
            check({7'h00, clk_out_en}, {7'h00, s == 1});
            repeat (16) @(posedge clk);
            count(0, n);
            check(8'(n), 8'((s == 2 ? 32 : 64) >> c));
            count(1, n);
            check(8'(n), 8'(s == 1 ? 32 >> c : 0));
            count(2, n);
            check(8'(n), clk_m[1] ? 8'h08 : 8'h10);
         end
      end
      // measurement path reset (bit 6 written 0, bit 7 kept 1): fixed length, bit low while active
      wr_reg(soft_reset_control_addr, 8'h80);
      count(3, n);
      check(8'(n), 8'h08);
      wr_reg(soft_reset_control_addr, 8'h80);
      rd_reg(soft_reset_control_addr, got);
      check(got, 8'h80);
      repeat (10) @(posedge clk);
      rd_reg(soft_reset_control_addr, got);
      check(got, 8'hc0);
      // undefined source code 11 must leave the pin undriven
      wr_reg(clock_control_addr, 8'hf4);
      @(negedge clk);
      check({7'h00, clk_out_en}, 8'h00);
      // whole device reset (bit 7 written 0) restores the clock control register
      wr_reg(soft_reset_control_addr, 8'h40);
      count(4, n);
      check(8'(n), 8'h08);
      rd_reg(clock_control_addr, got);
      check(got, 8'(clk_model));
      rd_reg(soft_reset_control_addr, got);
      check(got, 8'hc0);
      // writing ones starts nothing
      wr_reg(soft_reset_control_addr, 8'hff);
      count(3, n);
      check(8'(n), 8'h00);
      wr_reg(soft_reset_control_addr, 8'hff);
      count(4, n);
      check(8'(n), 8'h00);
      complete_run();
   end
endmodule : test_clock_select_and_soft_reset
